// File: rtl/dsm_core.sv
// Purpose: drive-profile state automaton for one servo axis
// Assumes: pins pass two flops here; register port is on sys_clk
// Notes:   transition 16 off unless enabled by config bit
//
// Contract
// - transition 5: disable operation drops drive function, power unchanged
// - transition 6: shutdown from switched on drops high-level power
// - transition 7: quick stop or disable voltage, ready to off, no action
// - transition 8: shutdown from operation drops drive and power
// - transition 9: disable voltage from operation drops drive and power
// - transition 10: disable voltage or quick stop from switched on drops power
// - transition 11: quick stop from operation starts quick stop
// - transition 12: quick stop done (option 0-4) or disable voltage drops all
// - transition 13: fault enters fault reaction
// - transition 14: fault reaction end enters fault, drops drive and power
// - transition 15: fault reset leaves fault only when no fault present
// - transition 16: enable operation in quick stop, option 5-8, re-enables
// - transition 16 is optional and off by default
// - axis enable needs safe stop interlock active
// - drive function only in operation, quick stop, fault reaction
// - reset runs init then moves automatically to switch on disabled
// - switch on powers up; enable operation enables drive, clears set-points
`timescale 1ns/1ps
`default_nettype none
module dsm_core
  import dsm_pkg::*;
#(
  parameter int unsigned TWIDTH     = 24,
  parameter int unsigned INIT_CNT   = dsm_pkg::INIT_CYC,
  parameter int unsigned QSTOP_CNT  = dsm_pkg::QSTOP_CYC,
  parameter int unsigned FREACT_CNT = dsm_pkg::FREACT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [2:0]  local_cmd,
  input  wire logic        local_cmd_stb,
  input  wire logic        fault_in,
  input  wire logic        safe_stop_interlock,
  output logic             drive_enable,
  output logic             hl_power_on,
  output logic             quick_stop_run,
  output logic             fault_react_run,
  output logic             setpoint_clear,
  output logic             comm_active
);

  // pin synchronisers
  logic [1:0] fault_sync;
  logic [1:0] sto_sync;
  logic [2:0] lcmd_s1;
  logic [2:0] lcmd_s2;
  logic [2:0] lstb_sync;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      fault_sync <= 2'h0;
      sto_sync   <= 2'h0;
      lcmd_s1    <= 3'h0;
      lcmd_s2    <= 3'h0;
      lstb_sync  <= 3'h0;
    end
    else
    begin
      fault_sync <= {fault_sync[0], fault_in};
      sto_sync   <= {sto_sync[0], safe_stop_interlock};
      lcmd_s1    <= local_cmd;
      lcmd_s2    <= lcmd_s1;
      lstb_sync  <= {lstb_sync[1:0], local_cmd_stb};
    end
  end

  wire fault_now = fault_sync[1];
  wire sto_ok    = sto_sync[1];
  // rising edge taken from the second and third flops only
  wire lstb_rise = lstb_sync[1] & ~lstb_sync[2];

  // config and command registers
  logic [5:0] cfg;
  logic [2:0] sw_cmd;
  logic       sw_cmd_stb;
  logic       fault_latched;
  dsm_state_t state;
  dsm_state_t next_state;

  // option field four bits wide so that codes 5 to 8 all fit
  wire [3:0] qs_opt   = cfg[CFG_QSOPT_LSB +: 4];
  wire       local_md = cfg[CFG_LOCAL_BIT];
  wire       t16_en   = cfg[CFG_T16_BIT];
  wire       wr_cmd   = reg_wr && (reg_addr == ADDR_CMD);
  wire       wr_cfg   = reg_wr && (reg_addr == ADDR_CFG);
  wire       wr_ctrl  = reg_wr && (reg_addr == ADDR_CTRL);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfg        <= {3'h0, QSOPT_RESET};
      sw_cmd     <= DSM_CMD_NONE;
      sw_cmd_stb <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg <= reg_wdata[5:0];
      sw_cmd_stb <= wr_cmd;
      if (wr_cmd)
        sw_cmd <= reg_wdata[2:0];
    end
  end

  // command source select: local pins or register port
  wire       cmd_valid = local_md ? lstb_rise : sw_cmd_stb;
  wire [2:0] cmd_raw   = local_md ? lcmd_s2 : sw_cmd;
  dsm_cmd_t  cmd;
  assign cmd = cmd_valid ? dsm_cmd_t'(cmd_raw) : DSM_CMD_NONE;

  function automatic logic opt_in(input logic [3:0] v, input logic [3:0] lo);
    opt_in = (v >= lo) && (v <= lo + 4'h3);
  endfunction

  // codes above 8 neither end nor resume: only disable voltage or a fault leaves
  wire qs_auto_stop = opt_in(qs_opt, 4'h1) || (qs_opt == 4'h0);
  wire qs_hold      = opt_in(qs_opt, 4'h5);

  // timer shared by init, quick stop and fault reaction
  logic              tmr_load;
  logic [TWIDTH-1:0] tmr_val;
  logic              tmr_done;
  logic              init_loaded;
  // init count goes in during the first cycle after reset release
  wire               init_tmr_load = !init_loaded;
  wire               tmr_run = (state == DSM_ST_INIT) || (state == DSM_ST_QSTOP)
                             || (state == DSM_ST_FREACT);

  dsm_timer #(
    .WIDTH (TWIDTH)
  ) u_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .run      (tmr_run),
    .done     (tmr_done)
  );

  // next-state logic
  always_comb
  begin
    next_state = state;
    unique case (state)
      DSM_ST_INIT:
        if (tmr_done)
          next_state = DSM_ST_NOTREADY;
      DSM_ST_NOTREADY:
        next_state = DSM_ST_SODIS;
      DSM_ST_SODIS:
        if (cmd == DSM_CMD_SHUTDOWN)
          next_state = DSM_ST_READY;
      DSM_ST_READY:
        if (cmd == DSM_CMD_SWITCHON)
          next_state = DSM_ST_SWON;
        else if (cmd == DSM_CMD_QSTOP || cmd == DSM_CMD_DISVOLT)
          next_state = DSM_ST_SODIS;
      DSM_ST_SWON:
        if (cmd == DSM_CMD_ENOP && sto_ok)
          next_state = DSM_ST_OPEN;
        else if (cmd == DSM_CMD_SHUTDOWN)
          next_state = DSM_ST_READY;
        else if (cmd == DSM_CMD_DISVOLT || cmd == DSM_CMD_QSTOP)
          next_state = DSM_ST_SODIS;
      DSM_ST_OPEN:
        if (cmd == DSM_CMD_DISOP)
          next_state = DSM_ST_SWON;
        else if (cmd == DSM_CMD_SHUTDOWN)
          next_state = DSM_ST_READY;
        else if (cmd == DSM_CMD_DISVOLT)
          next_state = DSM_ST_SODIS;
        else if (cmd == DSM_CMD_QSTOP)
          next_state = DSM_ST_QSTOP;
      DSM_ST_QSTOP:
        if (tmr_done && qs_auto_stop)
          next_state = DSM_ST_SODIS;
        else if (cmd == DSM_CMD_DISVOLT)
          next_state = DSM_ST_SODIS;
        else if (cmd == DSM_CMD_ENOP && t16_en && qs_hold && sto_ok)
          next_state = DSM_ST_OPEN;
      DSM_ST_FREACT:
        if (tmr_done)
          next_state = DSM_ST_FAULT;
      DSM_ST_FAULT:
        if (cmd == DSM_CMD_FRESET && !fault_now)
          next_state = DSM_ST_SODIS;
      default:
        next_state = DSM_ST_INIT;
    endcase
    // fault overrides any command this cycle
    if (fault_now && state != DSM_ST_FREACT && state != DSM_ST_FAULT
        && state != DSM_ST_INIT)
      next_state = DSM_ST_FREACT;
  end

  always_comb
  begin
    tmr_load = 1'b0;
    tmr_val  = '0;
    if (init_tmr_load)
    begin
      tmr_load = 1'b1;
      tmr_val  = TWIDTH'(INIT_CNT);
    end
    else if (next_state != state && next_state == DSM_ST_QSTOP)
    begin
      tmr_load = 1'b1;
      tmr_val  = TWIDTH'(QSTOP_CNT);
    end
    else if (next_state != state && next_state == DSM_ST_FREACT)
    begin
      tmr_load = 1'b1;
      tmr_val  = TWIDTH'(FREACT_CNT);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state         <= DSM_ST_INIT;
      init_loaded   <= 1'b0;
      fault_latched <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      init_loaded <= 1'b1;
      // hardware set wins over software clear
      if (fault_now)
        fault_latched <= 1'b1;
      else if (wr_ctrl && reg_wdata[0])
        fault_latched <= 1'b0;
    end
  end

  // outputs
  wire drv_state = (state == DSM_ST_OPEN) || (state == DSM_ST_QSTOP)
                 || (state == DSM_ST_FREACT);
  wire pwr_state = (state == DSM_ST_SWON) || drv_state;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      drive_enable    <= 1'b0;
      hl_power_on     <= 1'b0;
      quick_stop_run  <= 1'b0;
      fault_react_run <= 1'b0;
      setpoint_clear  <= 1'b0;
      comm_active     <= 1'b0;
    end
    else
    begin
      drive_enable    <= (next_state == DSM_ST_OPEN || next_state == DSM_ST_QSTOP
                         || next_state == DSM_ST_FREACT) && sto_ok;
      hl_power_on     <= (next_state == DSM_ST_SWON || next_state == DSM_ST_OPEN
                         || next_state == DSM_ST_QSTOP
                         || next_state == DSM_ST_FREACT);
      quick_stop_run  <= (next_state == DSM_ST_QSTOP);
      fault_react_run <= (next_state == DSM_ST_FREACT);
      setpoint_clear  <= (next_state == DSM_ST_OPEN) && (state != DSM_ST_OPEN);
      comm_active     <= (state != DSM_ST_INIT);
    end
  end

  // read port, data one cycle after strobe
  logic [31:0] rd_mux;
  assign rd_mux = (reg_addr == ADDR_CMD)    ? {29'h0, sw_cmd} :
                  (reg_addr == ADDR_CFG)    ? {26'h0, cfg} :
                  (reg_addr == ADDR_STATUS) ? {16'h0, 2'h0, sto_ok, fault_now,
                                               fault_latched, drv_state, pwr_state,
                                               state} :
                  32'h0;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 32'h0;
  end

  // assertions
  a_drive_states_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
    drive_enable |-> drv_state)
    else $error("drive enabled outside allowed state");
  a_interlock_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(sto_ok) |-> !drive_enable)
    else $error("drive enabled without interlock");
  a_disop_keeps_power: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == DSM_ST_OPEN && next_state == DSM_ST_SWON) |=> hl_power_on && !drive_enable)
    else $error("disable operation changed power");
  a_shutdown_power: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == DSM_ST_SWON && next_state == DSM_ST_READY) |=> !hl_power_on)
    else $error("shutdown kept power on");
  a_fault_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fault_now && state == DSM_ST_OPEN) |=> state == DSM_ST_FREACT)
    else $error("fault did not enter reaction");
  a_fault_reset_blk: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == DSM_ST_FAULT && fault_now) |=> state != DSM_ST_SODIS)
    else $error("left fault while fault present");
  a_freact_to_fault: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == DSM_ST_FREACT && tmr_done) |=> state == DSM_ST_FAULT ##1 !drive_enable)
    else $error("fault reaction did not end in fault");
  a_qstop_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == DSM_ST_OPEN && cmd == DSM_CMD_QSTOP && !fault_now) |=> quick_stop_run)
    else $error("quick stop not started");
  a_t16_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == DSM_ST_QSTOP && !t16_en) |=> state != DSM_ST_OPEN)
    else $error("return from quick stop while disabled");
  a_setpoint_on_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == DSM_ST_SWON && next_state == DSM_ST_OPEN) |=> setpoint_clear)
    else $error("set-points not cleared on enable");
  a_power_states_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hl_power_on |-> pwr_state)
    else $error("power on outside allowed state");

  c_enable_path: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state == DSM_ST_SWON ##1 state == DSM_ST_OPEN);
  c_quick_stop_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state == DSM_ST_QSTOP ##1 state == DSM_ST_SODIS);
  c_fault_cycle: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state == DSM_ST_FAULT ##1 state == DSM_ST_SODIS);
  c_fault_reaction: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state == DSM_ST_FREACT ##1 state == DSM_ST_FAULT);

endmodule // dsm_core
`default_nettype wire

// File: rtl/dsm_pkg.sv
// Purpose: shared constants and types for the drive state machine
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes:   register offsets index 32-bit words on the plain register port
package dsm_pkg;

  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned INIT_NS    = 1000;
  localparam int unsigned INIT_CYC   = (INIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned QSTOP_US   = 100;
  localparam int unsigned QSTOP_CYC  = QSTOP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FREACT_US  = 100;
  localparam int unsigned FREACT_CYC = FREACT_US * (CLK_HZ / 1_000_000);

  localparam logic [3:0] ADDR_CMD    = 4'h0;
  localparam logic [3:0] ADDR_CFG    = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CTRL   = 4'h3;

  localparam int unsigned CFG_QSOPT_LSB = 0;
  localparam int unsigned CFG_LOCAL_BIT = 4;
  localparam int unsigned CFG_T16_BIT   = 5;
  localparam logic [2:0]  QSOPT_RESET   = 3'h2;

  typedef enum logic [2:0] {
    DSM_CMD_NONE     = 3'h0,
    DSM_CMD_SHUTDOWN = 3'h1,
    DSM_CMD_SWITCHON = 3'h2,
    DSM_CMD_DISVOLT  = 3'h3,
    DSM_CMD_QSTOP    = 3'h4,
    DSM_CMD_DISOP    = 3'h5,
    DSM_CMD_ENOP     = 3'h6,
    DSM_CMD_FRESET   = 3'h7
  } dsm_cmd_t;

  typedef enum logic [8:0] {
    DSM_ST_INIT     = 9'h001,
    DSM_ST_NOTREADY = 9'h002,
    DSM_ST_SODIS    = 9'h004,
    DSM_ST_READY    = 9'h008,
    DSM_ST_SWON     = 9'h010,
    DSM_ST_OPEN     = 9'h020,
    DSM_ST_QSTOP    = 9'h040,
    DSM_ST_FREACT   = 9'h080,
    DSM_ST_FAULT    = 9'h100
  } dsm_state_t;

endpackage : dsm_pkg

// File: rtl/dsm_timer.sv
// Purpose: one-shot down counter timing init, quick stop and fault reaction
// Assumes: load and run come from the same clock domain
// Notes:   done is a one-cycle pulse when the count reaches zero
`timescale 1ns/1ps
`default_nettype none
module dsm_timer #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             run,
  output logic                  done
);

  logic [WIDTH-1:0] count;
  logic             armed;
  wire              at_zero = (count == '0);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      count <= '0;
      armed <= 1'b0;
      done  <= 1'b0;
    end
    else if (load)
    begin
      count <= load_val;
      armed <= 1'b1;
      done  <= 1'b0;
    end
    else
    begin
      done <= armed && run && at_zero;
      if (armed && run && at_zero)
        armed <= 1'b0;
      else if (armed && run)
        count <= count - 1'b1;
    end
  end

endmodule // dsm_timer
`default_nettype wire

// File: sim/dsm_cmd_src.sv
// Purpose: local command source standing in for the external controller
// Assumes: commands reach the core through its two-flop pin synchroniser
// Notes:   send() is called from the bench; code settles before the strobe rises
`timescale 1ns/1ps
`default_nettype none
module dsm_cmd_src
  import dsm_pkg::*;
(
  input  wire logic       sys_clk,
  output var  logic [2:0] cmd,
  output var  logic       stb
);
  import dsm_pkg::*;

  initial
  begin
    cmd = DSM_CMD_NONE;
    stb = 1'b0;
  end

  // strobe held several cycles so the synchroniser cannot miss it
  task automatic send(input dsm_cmd_t c);
    @(posedge sys_clk);
    cmd <= c;
    @(posedge sys_clk);
    stb <= 1'b1;
    repeat (4) @(posedge sys_clk);
    stb <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cmd <= DSM_CMD_NONE;
  endtask
endmodule // dsm_cmd_src
`default_nettype wire

// File: sim/dsm_core_bench.sv
// Purpose: self-checking bench for the drive state automaton
// Assumes: short timer parameters; command register drives transitions except the last fault reset, sent on local pins
// Notes:   fault-vs-command race is not aligned here, pin sync makes it loose
`timescale 1ns/1ps
`default_nettype none
module dsm_core_bench;
  import dsm_pkg::*;

  localparam int unsigned QN = 40;

  logic        sys_clk;
  logic        rst_n;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  logic [2:0]  local_cmd;
  logic        local_cmd_stb;
  logic        fault_in;
  logic        safe_stop_interlock;
  logic        drive_enable;
  logic        hl_power_on;
  logic        quick_stop_run;
  logic        fault_react_run;
  logic        setpoint_clear;
  logic        comm_active;
  logic        sp_seen;
  int          error_cnt;
  int          checks_done;

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  dsm_core #(.INIT_CNT(4), .QSTOP_CNT(QN), .FREACT_CNT(QN)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .local_cmd(local_cmd),
    .local_cmd_stb(local_cmd_stb), .fault_in(fault_in),
    .safe_stop_interlock(safe_stop_interlock), .drive_enable(drive_enable),
    .hl_power_on(hl_power_on), .quick_stop_run(quick_stop_run),
    .fault_react_run(fault_react_run), .setpoint_clear(setpoint_clear),
    .comm_active(comm_active)
  );

  dsm_cmd_src i_src (.sys_clk(sys_clk), .cmd(local_cmd), .stb(local_cmd_stb));

  // pulse is one cycle wide, so latch it rather than poll
  always @(posedge sys_clk)
    if (setpoint_clear === 1'b1)
      sp_seen <= 1'b1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    // data stand only in the cycle after the strobe: take them mid-cycle
    @(negedge sys_clk);
    rd_val = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic do_cmd(input dsm_cmd_t c);
    wr(ADDR_CMD, {29'h0, c});
    wait_cyc(4);
  endtask

  task automatic st(input dsm_state_t s, input logic p, input logic d);
    rd(ADDR_STATUS);
    check({21'h0, rd_val[10:0]}, {21'h0, d, p, s});
  endtask

  // quick stop and fault reaction leave drive and power open, so state only
  task automatic st_only(input dsm_state_t s);
    rd(ADDR_STATUS);
    check({23'h0, rd_val[8:0]}, {23'h0, s});
  endtask

  task automatic go_open();
    do_cmd(DSM_CMD_SHUTDOWN);
    do_cmd(DSM_CMD_SWITCHON);
    do_cmd(DSM_CMD_ENOP);
  endtask

  initial
  begin
    int k;
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fault_in = 1'b0;
    safe_stop_interlock = 1'b1;
    sp_seen = 1'b0;
    rd_val = 32'h0;
    error_cnt = 0;
    checks_done = 0;
    wait_cyc(12);
    #1 check({28'h0, drive_enable, hl_power_on, quick_stop_run, comm_active}, 32'h0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    for (k = 0; k < 50 && rd_val[8:0] !== DSM_ST_SODIS; k++)
      rd(ADDR_STATUS);
    if (rd_val[8:0] !== DSM_ST_SODIS)
    begin
      error_cnt++;
      print_verdict();
    end
    check({31'h0, comm_active}, 32'h1);
    do_cmd(DSM_CMD_ENOP);
    st(DSM_ST_SODIS, 1'b0, 1'b0);
    rd(4'hc);
    check(rd_val, 32'h0);
    safe_stop_interlock <= 1'b0;
    go_open();
    st(DSM_ST_SWON, 1'b1, 1'b0);
    safe_stop_interlock <= 1'b1;
    sp_seen = 1'b0;
    do_cmd(DSM_CMD_ENOP);
    st(DSM_ST_OPEN, 1'b1, 1'b1);
    check({31'h0, sp_seen}, 32'h1);
    do_cmd(DSM_CMD_DISOP);
    st(DSM_ST_SWON, 1'b1, 1'b0);
    check({30'h0, hl_power_on, drive_enable}, 32'h2);
    do_cmd(DSM_CMD_SHUTDOWN);
    st(DSM_ST_READY, 1'b0, 1'b0);
    do_cmd(DSM_CMD_QSTOP);
    st(DSM_ST_SODIS, 1'b0, 1'b0);
    do_cmd(DSM_CMD_SHUTDOWN);
    do_cmd(DSM_CMD_DISVOLT);
    st(DSM_ST_SODIS, 1'b0, 1'b0);
    go_open();
    do_cmd(DSM_CMD_SHUTDOWN);
    st(DSM_ST_READY, 1'b0, 1'b0);
    go_open();
    do_cmd(DSM_CMD_DISVOLT);
    st(DSM_ST_SODIS, 1'b0, 1'b0);
    do_cmd(DSM_CMD_SHUTDOWN);
    do_cmd(DSM_CMD_SWITCHON);
    do_cmd(DSM_CMD_DISVOLT);
    st(DSM_ST_SODIS, 1'b0, 1'b0);
    do_cmd(DSM_CMD_SHUTDOWN);
    do_cmd(DSM_CMD_SWITCHON);
    do_cmd(DSM_CMD_QSTOP);
    st(DSM_ST_SODIS, 1'b0, 1'b0);
    go_open();
    safe_stop_interlock <= 1'b0;
    wait_cyc(6);
    check({31'h0, drive_enable}, 32'h0);
    safe_stop_interlock <= 1'b1;
    do_cmd(DSM_CMD_DISVOLT);
    go_open();
    do_cmd(DSM_CMD_QSTOP);
    check({31'h0, quick_stop_run}, 32'h1);
    st_only(DSM_ST_QSTOP);
    wait_cyc(QN + 10);
    st(DSM_ST_SODIS, 1'b0, 1'b0);
    wr(ADDR_CFG, 32'h5);
    go_open();
    do_cmd(DSM_CMD_QSTOP);
    wait_cyc(QN + 10);
    st_only(DSM_ST_QSTOP);
    do_cmd(DSM_CMD_ENOP);
    st_only(DSM_ST_QSTOP);
    do_cmd(DSM_CMD_DISVOLT);
    st(DSM_ST_SODIS, 1'b0, 1'b0);
    wr(ADDR_CFG, 32'h25);
    go_open();
    do_cmd(DSM_CMD_QSTOP);
    do_cmd(DSM_CMD_ENOP);
    st(DSM_ST_OPEN, 1'b1, 1'b1);
    fault_in <= 1'b1;
    wait_cyc(6);
    check({31'h0, fault_react_run}, 32'h1);
    st_only(DSM_ST_FREACT);
    wait_cyc(QN + 10);
    st(DSM_ST_FAULT, 1'b0, 1'b0);
    do_cmd(DSM_CMD_FRESET);
    st(DSM_ST_FAULT, 1'b0, 1'b0);
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_STATUS);
    check({30'h0, rd_val[12:11]}, 32'h3);
    fault_in <= 1'b0;
    wait_cyc(4);
    wr(ADDR_CFG, 32'h12);
    i_src.send(DSM_CMD_FRESET);
    wait_cyc(4);
    st(DSM_ST_SODIS, 1'b0, 1'b0);
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_STATUS);
    check({30'h0, rd_val[12:11]}, 32'h0);
    // second reset in mid-run must bring back init and the default config
    rst_n <= 1'b0;
    wait_cyc(3);
    check({28'h0, drive_enable, hl_power_on, fault_react_run, comm_active}, 32'h0);
    rst_n <= 1'b1;
    wait_cyc(20);
    st(DSM_ST_SODIS, 1'b0, 1'b0);
    rd(ADDR_CFG);
    check(rd_val, {26'h0, 3'h0, QSOPT_RESET});
    print_verdict();
  end
endmodule // dsm_core_bench
`default_nettype wire
